// file: common/etms_regs.svh
`ifndef ETMS_REGS_SVH
`define ETMS_REGS_SVH

// Register byte addresses.
`define ETMS_A_CTRL      8'h00
`define ETMS_A_RXMAX     8'h04
`define ETMS_A_TXMAX     8'h08
`define ETMS_A_NEG       8'h0C
`define ETMS_A_RESP      8'h10
`define ETMS_A_SENSOR    8'h14
`define ETMS_A_STATE     8'h18
`define ETMS_A_READING   8'h1C
`define ETMS_A_OVERHEAD  8'h20
`define ETMS_A_CMD       8'h24
`define ETMS_A_STATUS    8'h28
`define ETMS_A_MASK      8'h2C
`define ETMS_A_FSM       8'h30

// Field positions.
`define ETMS_CTRL_NEG_EN   0
`define ETMS_CTRL_PRIOR_UNK 1
`define ETMS_CMD_SEND      0
`define ETMS_CMD_POLL      1
`define ETMS_ST_SENT       0
`define ETMS_ST_POLL       1
`define ETMS_ST_BAD        2
`define ETMS_ST_NEG        3

// Reset values and fixed figures.
`define ETMS_DEFAULT_SIZE  16'h0100
`define ETMS_TXMAX_RESET   16'h0400
`define ETMS_OVH_RESET     16'h000C
`define ETMS_CTRL_RESET    2'b01
`define ETMS_RC_SUCCESS    8'h00
`define ETMS_RC_UNSUPP     8'h05
`define ETMS_MAX_OFFSET    8'h07

`endif

// file: common/etms_pkg.sv
package etms_pkg;

  typedef enum logic [5:0] {
    ETMS_IDLE  = 6'b00_0001,
    ETMS_BUILD = 6'b00_0010,
    ETMS_DECIDE = 6'b00_0100,
    ETMS_WAIT  = 6'b00_1000,
    ETMS_SEND  = 6'b01_0000,
    ETMS_DRAIN = 6'b10_0000
  } etms_fsm_t;

  typedef enum logic [7:0] {
    ETMS_OP_STATE_CHANGE  = 8'h00,
    ETMS_DISCRETE_CHANGE  = 8'h01,
    ETMS_NUMERIC_CHANGE   = 8'h02
  } etms_kind_t;

  typedef enum logic [7:0] {
    ETMS_FMT_U8  = 8'h00,
    ETMS_FMT_S8  = 8'h01,
    ETMS_FMT_U16 = 8'h02,
    ETMS_FMT_S16 = 8'h03,
    ETMS_FMT_U32 = 8'h04,
    ETMS_FMT_S32 = 8'h05
  } etms_fmt_t;

endpackage

// file: verilog/etms_frame_mem.sv
`timescale 1ns/1ps
`include "etms_regs.svh"

module etms_frame_mem
  import etms_pkg::*;
(
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Write side.
  input  wire logic       wr_en,
  input  wire logic [3:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // Read side.
  input  wire logic [3:0] rd_addr,
  output logic      [7:0] rd_data_q
);

  typedef struct packed {
    logic [15:0][7:0] mem;
    logic [7:0]       rd;
  } etms_mem_state_t;

  etms_mem_state_t s_q;
  etms_mem_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (wr_en)
    begin
      s_d.mem[wr_addr] = wr_data;
    end
    s_d.rd = s_q.mem[rd_addr];
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rd_data_q = s_q.rd;

endmodule // etms_frame_mem

// file: verilog/etms_size_neg.sv
`timescale 1ns/1ps
`include "etms_regs.svh"

module etms_size_neg
  import etms_pkg::*;
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Negotiation request.
  input  wire logic        neg_cmd,
  input  wire logic [15:0] receiver_max_event_size,
  input  wire logic [15:0] sender_max_event_size,
  // Size check.
  input  wire logic [16:0] msg_len,
  output logic      [15:0] neg_size_q,
  output logic             oversize_q
);

  typedef struct packed {
    logic [15:0] neg;
    logic        over;
  } etms_neg_state_t;

  etms_neg_state_t s_q;
  etms_neg_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (neg_cmd)
    begin
      s_d.neg = (receiver_max_event_size < sender_max_event_size) ?
                receiver_max_event_size : sender_max_event_size; // RL1
    end
    // The limit gates direct delivery only; a polled message goes out whole at any length.
    s_d.over = msg_len > {1'b0, s_q.neg}; // RL7
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s_q.neg  <= `ETMS_DEFAULT_SIZE; // RL4
      s_q.over <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign neg_size_q = s_q.neg;
  assign oversize_q = s_q.over;

endmodule // etms_size_neg

// file: verilog/etms_event_top.sv
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "etms_regs.svh"

//
// Summary of operation
// RL1 - Negotiated size is smaller of two maxima.
// RL2 - Receiver polls to fetch oversized messages.
// RL3 - Oversized message triggers poll notification instead.
// RL4 - Default negotiated size is 256 bytes.
// RL5 - Request carries 16-bit receiver maximum size.
// RL6 - Response: 8-bit result code, 16-bit sender size.
// RL7 - Negotiated size applies to every delivery; here it limits only direct delivery, a polled message goes out whole.
// RL8 - Event data begins with 16-bit sensor identifier.
// RL9 - 8-bit event kind follows, three values.
// RL10 - Composite member index legal zero to seven.
// RL11 - Discrete events carry new state value.
// RL12 - Negotiation command supported when receiver configurable.
// RL13 - Unknown prior state equals new state.
// RL14 - Numeric events carry format and sized reading.
// RL15 - Fields little endian, packed, in order.

module etms_event_top
  import etms_pkg::*;
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Register port.
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata_q,
  // Event byte stream.
  output logic      [7:0]  evt_byte_q,
  output logic             evt_valid_q,
  output logic             evt_last_q,
  // Poll notification and interrupt.
  output logic             poll_needed_notification_q,
  output logic             irq_q
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [1:0]  ctrl;
    logic [15:0] tx_max;
    logic [7:0]  result_code;
    logic [15:0] neg_rx;
    logic        neg_cmd;
    logic [15:0] sensor_identifier;
    logic [7:0]  sensor_event_kind;
    logic [7:0]  composite_member_index;
    logic [7:0]  new_state_value;
    logic [7:0]  prior_state_value;
    logic [7:0]  reading_format;
    logic [31:0] current_reading;
    logic [15:0] overhead;
    logic [3:0]  status;
    logic [3:0]  mask;
    etms_fsm_t   fsm;
    logic [3:0]  idx;
    logic [3:0]  len;
    logic        vpipe;
    logic        lpipe;
    logic [31:0] rdata;
    logic [7:0]  evt_byte;
    logic        evt_valid;
    logic        evt_last;
    logic        poll_note;
    logic        irq;
  } etms_state_t;

  etms_state_t s_q;
  etms_state_t s_d;

  logic [15:0]  neg_size;
  logic         oversize;
  logic [7:0]   mem_rd_data;
  logic         mem_wr;
  logic [3:0]   mem_rd_addr;
  logic [111:0] frame_v;
  logic [7:0]   prior_eff;
  logic [3:0]   frame_len;
  logic         fields_ok;
  logic [16:0]  msg_len;
  logic [3:0]   ev_set;

  ////////////////////////////////////////////////////////////////////////////

  etms_size_neg u_neg (
    .clock                   (clock),
    .rst_n                   (rst_n),
    .neg_cmd                 (s_q.neg_cmd),
    .receiver_max_event_size (s_q.neg_rx),
    .sender_max_event_size   (s_q.tx_max),
    .msg_len                 (msg_len),
    .neg_size_q              (neg_size),
    .oversize_q              (oversize)
  );

  etms_frame_mem u_mem (
    .clock     (clock),
    .rst_n     (rst_n),
    .wr_en     (mem_wr),
    .wr_addr   (s_q.idx),
    .wr_data   (frame_v[{s_q.idx, 3'b000} +: 8]),
    .rd_addr   (mem_rd_addr),
    .rd_data_q (mem_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////

  // Message length as counted against the negotiated size: header plus data.
  assign msg_len     = {1'b0, s_q.overhead} + {13'd0, s_q.len};
  assign mem_wr      = s_q.fsm == ETMS_BUILD;
  assign mem_rd_addr = s_q.idx;

  // Frame image, byte 0 in the low bits, so the stream goes out LSB first.
  always_comb
  begin
    prior_eff = s_q.ctrl[`ETMS_CTRL_PRIOR_UNK] ? s_q.new_state_value : s_q.prior_state_value; // RL13
    frame_v   = '0;
    frame_len = 4'd0;
    fields_ok = 1'b1;
    unique case (s_q.sensor_event_kind)
      ETMS_OP_STATE_CHANGE:
      begin
        frame_v[39:0] = {prior_eff, s_q.new_state_value, s_q.sensor_event_kind,
                         s_q.sensor_identifier}; // RL15
        frame_len = 4'd5;
      end
      ETMS_DISCRETE_CHANGE:
      begin
        frame_v[47:0] = {prior_eff, s_q.new_state_value, s_q.composite_member_index,
                         s_q.sensor_event_kind, s_q.sensor_identifier}; // RL11
        frame_len = 4'd6;
        fields_ok = s_q.composite_member_index <= `ETMS_MAX_OFFSET; // RL10
      end
      ETMS_NUMERIC_CHANGE:
      begin
        // The reading is stored whole; the length cuts it to its format, so no pad byte goes out.
        frame_v[79:0] = {s_q.current_reading, s_q.reading_format, prior_eff,
                         s_q.new_state_value, s_q.sensor_event_kind, s_q.sensor_identifier}; // RL14
        unique case (s_q.reading_format)
          ETMS_FMT_U8, ETMS_FMT_S8:   frame_len = 4'd7;
          ETMS_FMT_U16, ETMS_FMT_S16: frame_len = 4'd8;
          ETMS_FMT_U32, ETMS_FMT_S32: frame_len = 4'd10;
          default:                    fields_ok = 1'b0;
        endcase
      end
      default:
      begin
        fields_ok = 1'b0; // RL9
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    s_d           = s_q;
    ev_set        = 4'd0;
    s_d.neg_cmd   = 1'b0;
    s_d.poll_note = 1'b0;
    s_d.rdata     = 32'h0000_0000;

    // Register writes.
    if (reg_wr)
    begin
      unique case (reg_addr)
        `ETMS_A_CTRL:     s_d.ctrl = reg_wdata[1:0];
        `ETMS_A_RXMAX:
        begin
          // The write itself is the negotiation request from the receiver.
          if (s_q.ctrl[`ETMS_CTRL_NEG_EN]) // RL12
          begin
            s_d.neg_rx      = reg_wdata[15:0]; // RL5
            s_d.neg_cmd     = 1'b1;
            s_d.result_code = `ETMS_RC_SUCCESS;
            ev_set[`ETMS_ST_NEG] = 1'b1;
          end
          else
          begin
            s_d.result_code = `ETMS_RC_UNSUPP;
          end
        end
        `ETMS_A_TXMAX:    s_d.tx_max = reg_wdata[15:0];
        `ETMS_A_SENSOR:
        begin
          s_d.sensor_identifier      = reg_wdata[15:0]; // RL8
          s_d.sensor_event_kind      = reg_wdata[23:16];
          s_d.composite_member_index = reg_wdata[31:24];
        end
        `ETMS_A_STATE:
        begin
          s_d.new_state_value   = reg_wdata[7:0];
          s_d.prior_state_value = reg_wdata[15:8];
          s_d.reading_format    = reg_wdata[23:16];
        end
        `ETMS_A_READING:  s_d.current_reading = reg_wdata;
        `ETMS_A_OVERHEAD: s_d.overhead = reg_wdata[15:0];
        `ETMS_A_MASK:     s_d.mask = reg_wdata[3:0];
        default:          ;
      endcase
    end

    // Register reads, data in the following cycle.
    if (reg_rd)
    begin
      unique case (reg_addr)
        `ETMS_A_CTRL:     s_d.rdata = {30'd0, s_q.ctrl};
        `ETMS_A_RXMAX:    s_d.rdata = {16'd0, s_q.neg_rx};
        `ETMS_A_TXMAX:    s_d.rdata = {16'd0, s_q.tx_max};
        `ETMS_A_NEG:      s_d.rdata = {16'd0, neg_size};
        `ETMS_A_RESP:     s_d.rdata = {8'd0, s_q.tx_max, s_q.result_code}; // RL6
        `ETMS_A_SENSOR:   s_d.rdata = {s_q.composite_member_index, s_q.sensor_event_kind,
                                       s_q.sensor_identifier};
        `ETMS_A_STATE:    s_d.rdata = {8'd0, s_q.reading_format, s_q.prior_state_value,
                                       s_q.new_state_value};
        `ETMS_A_READING:  s_d.rdata = s_q.current_reading;
        `ETMS_A_OVERHEAD: s_d.rdata = {16'd0, s_q.overhead};
        `ETMS_A_STATUS:   s_d.rdata = {28'd0, s_q.status};
        `ETMS_A_MASK:     s_d.rdata = {28'd0, s_q.mask};
        `ETMS_A_FSM:      s_d.rdata = {22'd0, s_q.fsm, s_q.len};
        default:          s_d.rdata = 32'h0000_0000;
      endcase
    end

    // Read pipeline: the memory answers one cycle after the address.
    s_d.vpipe     = 1'b0;
    s_d.lpipe     = 1'b0;
    s_d.evt_byte  = mem_rd_data;
    s_d.evt_valid = s_q.vpipe;
    s_d.evt_last  = s_q.lpipe;

    unique case (s_q.fsm)
      ETMS_IDLE:
      begin
        if (reg_wr && reg_addr == `ETMS_A_CMD && reg_wdata[`ETMS_CMD_SEND])
        begin
          if (fields_ok)
          begin
            s_d.len = frame_len;
            s_d.idx = 4'd0;
            s_d.fsm = ETMS_BUILD;
          end
          else
          begin
            ev_set[`ETMS_ST_BAD] = 1'b1; // RL10
          end
        end
      end
      ETMS_BUILD:
      begin
        // The fields are snapshotted into the frame memory, so software may
        // load the next event while this one waits for a poll.
        s_d.idx = s_q.idx + 4'd1;
        if (s_q.idx == s_q.len - 4'd1)
        begin
          s_d.fsm = ETMS_DECIDE;
        end
      end
      ETMS_DECIDE:
      begin
        s_d.idx = 4'd0;
        if (oversize)
        begin
          s_d.poll_note = 1'b1; // RL3
          ev_set[`ETMS_ST_POLL] = 1'b1;
          s_d.fsm = ETMS_WAIT;
        end
        else
        begin
          s_d.fsm = ETMS_SEND;
        end
      end
      ETMS_WAIT:
      begin
        // Held until the receiver fetches the message with a poll command.
        if (reg_wr && reg_addr == `ETMS_A_CMD && reg_wdata[`ETMS_CMD_POLL]) // RL2
        begin
          s_d.fsm = ETMS_SEND;
        end
      end
      ETMS_SEND:
      begin
        s_d.vpipe = 1'b1;
        s_d.lpipe = s_q.idx == s_q.len - 4'd1;
        s_d.idx   = s_q.idx + 4'd1;
        if (s_q.idx == s_q.len - 4'd1)
        begin
          s_d.fsm = ETMS_DRAIN;
        end
      end
      ETMS_DRAIN:
      begin
        if (s_q.evt_last)
        begin
          ev_set[`ETMS_ST_SENT] = 1'b1;
          s_d.fsm = ETMS_IDLE;
        end
      end
    endcase

    // Write one to clear; an event in the same cycle keeps its bit set.
    if (reg_wr && reg_addr == `ETMS_A_STATUS)
    begin
      s_d.status = s_q.status & ~reg_wdata[3:0];
    end
    s_d.status = s_d.status | ev_set;
    s_d.irq    = |(s_d.status & s_d.mask);
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s_q        <= '0;
      s_q.fsm    <= ETMS_IDLE;
      s_q.tx_max <= `ETMS_TXMAX_RESET;
      s_q.neg_rx <= `ETMS_DEFAULT_SIZE;
      s_q.overhead <= `ETMS_OVH_RESET;
      s_q.ctrl   <= `ETMS_CTRL_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_q                = s_q.rdata;
  assign evt_byte_q                 = s_q.evt_byte;
  assign evt_valid_q                = s_q.evt_valid;
  assign evt_last_q                 = s_q.evt_last;
  assign poll_needed_notification_q = s_q.poll_note;
  assign irq_q                      = s_q.irq;

endmodule // etms_event_top

// file: testbench/etms_event_props.sv
`timescale 1ns/1ps

module etms_event_props (
  // Watched top ports.
  input wire logic clock,
  input wire logic rst_n,
  input wire logic evt_valid_q,
  input wire logic evt_last_q,
  input wire logic poll_needed_notification_q,
  input wire logic irq_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  last_in_frame_a:
    assert property (evt_last_q |-> evt_valid_q) else $error("last byte without valid");
  frame_close_a:
    assert property (evt_last_q |=> !evt_valid_q) else $error("byte after last");
  frame_gapless_a:
    assert property ($fell(evt_valid_q) |-> $past(evt_last_q)) else $error("frame broken before last");
  frame_min_a:
    assert property ($rose(evt_valid_q) |-> evt_valid_q [*5]) else $error("frame shorter than five");
  early_last_a:
    assert property ($rose(evt_valid_q) |-> !evt_last_q [*4]) else $error("frame ends too early");
  frame_max_a:
    assert property ($rose(evt_valid_q) |-> ##[4:9] evt_last_q) else $error("frame longer than ten");
  poll_pulse_a:
    assert property (poll_needed_notification_q |=> !poll_needed_notification_q) else $error("poll pulse too long");
  poll_no_data_a:
    assert property (poll_needed_notification_q |-> !evt_valid_q [*3]) else $error("data sent with poll notice");

  // Main scenarios seen at least once.
  cover property (evt_last_q);
  cover property (poll_needed_notification_q);
  cover property ($rose(irq_q));
endmodule // etms_event_props

bind etms_event_top etms_event_props u_props (
  .clock(clock),
  .rst_n(rst_n),
  .evt_valid_q(evt_valid_q),
  .evt_last_q(evt_last_q),
  .poll_needed_notification_q(poll_needed_notification_q),
  .irq_q(irq_q)
);

// file: testbench/etms_receiver_model.sv
`timescale 1ns/1ps

module etms_receiver_model (
  // Event stream from the terminus.
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic [7:0] evt_byte_q,
  input wire logic       evt_valid_q,
  input wire logic       evt_last_q,
  input wire logic       poll_needed_notification_q
);
  logic [7:0] got [0:15];
  int         n      = 0;
  int         len    = 0;
  int         frames = 0;
  int         polls  = 0;

  // The receiver only listens; it keeps whole frames, least significant byte first as they arrive.
  always @(posedge clock)
  begin
    if (rst_n && evt_valid_q)
    begin
      got[n[3:0]] <= evt_byte_q;
      n <= evt_last_q ? 0 : n + 1;
    end
    if (rst_n && evt_last_q)
    begin
      len <= n + 1;
      frames <= frames + 1;
    end
    if (rst_n && poll_needed_notification_q)
      polls <= polls + 1;
  end
endmodule // etms_receiver_model

// file: testbench/test_event_msg_size_and_sensor_fmt.sv
`timescale 1ns/1ps
`include "etms_regs.svh"

module test_event_msg_size_and_sensor_fmt;
  typedef struct {logic [31:0] sen; logic [31:0] sta; logic [31:0] rdg;} etms_row_t;
  logic        clock;
  logic        rst_n;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata_q;
  logic [7:0]  evt_byte_q;
  logic        evt_valid_q;
  logic        evt_last_q;
  logic        poll_needed_notification_q;
  logic        irq_q;
  int          failures = 0;
  int          total_checks = 0;
  logic [7:0]  exp_b [0:15];
  int          exp_len;
  etms_row_t   rows [8] = '{'{32'h0000_1234, 32'h0000_0203, 32'h0000_0000},
    '{32'h0701_BEEF, 32'h0000_0405, 32'h0000_0000}, '{32'h0002_00A5, 32'h0000_0102, 32'h8765_4321},
    '{32'h0002_00A5, 32'h0001_0102, 32'h8765_4321}, '{32'h0002_00A5, 32'h0002_0102, 32'h8765_4321},
    '{32'h0002_00A5, 32'h0003_0102, 32'h8765_4321}, '{32'h0002_00A5, 32'h0004_0102, 32'h8765_4321},
    '{32'h0002_00A5, 32'h0005_0102, 32'h8765_4321}};

  etms_event_top DUT (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .evt_byte_q(evt_byte_q),
    .evt_valid_q(evt_valid_q), .evt_last_q(evt_last_q),
    .poll_needed_notification_q(poll_needed_notification_q), .irq_q(irq_q));
  etms_receiver_model RX (.clock(clock), .rst_n(rst_n), .evt_byte_q(evt_byte_q),
    .evt_valid_q(evt_valid_q), .evt_last_q(evt_last_q),
    .poll_needed_notification_q(poll_needed_notification_q));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are sampled just after that edge.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata_q, e, m);
  endtask

  task automatic wait_cnt(input bit poll, input int c0);
    for (int t = 0; t < 60 && (poll ? RX.polls : RX.frames) == c0; t++)
    begin
      @(posedge clock);
      #1;
    end
  endtask

  task automatic exp_frame(input etms_row_t r, input bit unk);
    int nb;
    exp_b[0] = r.sen[7:0];
    exp_b[1] = r.sen[15:8];
    exp_b[2] = r.sen[23:16];
    exp_b[3] = r.sen[31:24];
    exp_len = (r.sen[23:16] == 8'h01) ? 4 : 3;
    exp_b[exp_len] = r.sta[7:0];
    exp_b[exp_len + 1] = unk ? r.sta[7:0] : r.sta[15:8];
    exp_len += 2;
    if (r.sen[23:16] == 8'h02)
    begin
      exp_b[5] = r.sta[23:16];
      nb = (r.sta[23:16] < 2) ? 1 : (r.sta[23:16] < 4) ? 2 : 4;
      for (int i = 0; i < nb; i++)
        exp_b[6 + i] = r.rdg[8 * i +: 8];
      exp_len = 6 + nb;
    end
  endtask

  task automatic send(input etms_row_t r, input bit unk, input bit over);
    int f0;
    int p0;
    f0 = RX.frames;
    p0 = RX.polls;
    wr(`ETMS_A_SENSOR, r.sen);
    wr(`ETMS_A_STATE, r.sta);
    wr(`ETMS_A_READING, r.rdg);
    wr(`ETMS_A_CMD, 32'h0000_0001);
    if (over)
    begin
      wait_cnt(1'b1, p0);
      chk(RX.polls - p0, 1, "poll notice");
      chk(RX.frames - f0, 0, "oversized frame held back");
      wr(`ETMS_A_CMD, 32'h0000_0002);
    end
    wait_cnt(1'b0, f0);
    exp_frame(r, unk);
    chk(RX.frames - f0, 1, "frame count");
    chk(RX.len, exp_len, "frame length");
    for (int i = 0; i < exp_len; i++)
      chk(RX.got[i], exp_b[i], "frame byte");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(100 * 4000);
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial
  begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    rd(`ETMS_A_NEG, 32'h0000_0100, "default size");
    rd(`ETMS_A_RESP, 32'h0004_0000, "response reset");
    rd(`ETMS_A_CTRL, 32'h0000_0001, "ctrl reset");
    rd(`ETMS_A_OVERHEAD, 32'h0000_000C, "overhead reset");
    rd(8'h40, 32'h0000_0000, "unmapped read");
    $display("reset test done");
    foreach (rows[i])
      send(rows[i], 1'b0, 1'b0);
    $display("row tests done");
    wr(`ETMS_A_CTRL, 32'h0000_0003);
    send(rows[1], 1'b1, 1'b0);
    wr(`ETMS_A_CTRL, 32'h0000_0001);
    wr(`ETMS_A_RXMAX, 32'h0000_0010);
    rd(`ETMS_A_NEG, 32'h0000_0010, "receiver smaller");
    send(rows[1], 1'b0, 1'b1);
    wr(`ETMS_A_TXMAX, 32'h0000_0011);
    wr(`ETMS_A_RXMAX, 32'h0000_FFFF);
    rd(`ETMS_A_NEG, 32'h0000_0011, "sender smaller");
    rd(`ETMS_A_RESP, 32'h0000_1100, "response fields");
    // Seventeen bytes against seventeen: equal fits, eighteen must go by poll.
    send(rows[0], 1'b0, 1'b0);
    send(rows[1], 1'b0, 1'b1);
    $display("negotiation tests done");
    wr(`ETMS_A_CTRL, 32'h0000_0000);
    wr(`ETMS_A_RXMAX, 32'h0000_0020);
    rd(`ETMS_A_NEG, 32'h0000_0011, "size kept when disabled");
    rd(`ETMS_A_RESP, 32'h0000_1105, "unsupported code");
    wr(`ETMS_A_CTRL, 32'h0000_0001);
    wr(`ETMS_A_STATUS, 32'h0000_000F);
    wr(`ETMS_A_SENSOR, 32'h0801_BEEF);
    wr(`ETMS_A_CMD, 32'h0000_0001);
    repeat (20) @(posedge clock);
    rd(`ETMS_A_STATUS, 32'h0000_0004, "bad member index");
    wr(`ETMS_A_STATUS, 32'h0000_000F);
    wr(`ETMS_A_SENSOR, 32'h0003_BEEF);
    wr(`ETMS_A_CMD, 32'h0000_0001);
    repeat (20) @(posedge clock);
    rd(`ETMS_A_STATUS, 32'h0000_0004, "bad event kind");
    wr(`ETMS_A_STATUS, 32'h0000_000F);
    wr(`ETMS_A_SENSOR, 32'h0002_BEEF);
    wr(`ETMS_A_STATE, 32'h0006_0102);
    wr(`ETMS_A_CMD, 32'h0000_0001);
    repeat (20) @(posedge clock);
    rd(`ETMS_A_STATUS, 32'h0000_0004, "bad reading format");
    $display("refusal test done");
    wr(`ETMS_A_STATUS, 32'h0000_000F);
    send(rows[0], 1'b0, 1'b0);
    repeat (3) @(posedge clock);
    #1 chk(irq_q, 1'b0, "irq masked");
    wr(`ETMS_A_MASK, 32'h0000_0001);
    repeat (3) @(posedge clock);
    #1 chk(irq_q, 1'b1, "irq raised");
    wr(`ETMS_A_STATUS, 32'h0000_0001);
    repeat (3) @(posedge clock);
    #1 chk(irq_q, 1'b0, "irq cleared");
    $display("interrupt test done");
    wrap_up();
  end
endmodule // test_event_msg_size_and_sensor_fmt
